//--- core/aux_cal_pkg.sv
// Register map, field positions and reset values of the aux/ref/cal slice
package aux_cal_pkg;
    // Register offsets
    localparam logic [7:0] ADDR_AUX_I_LOW  = 8'h09;
    localparam logic [7:0] ADDR_AUX_I_CTL  = 8'h0A;
    localparam logic [7:0] ADDR_AUX_Q_LOW  = 8'h0B;
    localparam logic [7:0] ADDR_AUX_Q_CTL  = 8'h0C;
    localparam logic [7:0] ADDR_REF_TRIM   = 8'h0D;
    localparam logic [7:0] ADDR_CAL_CTL    = 8'h0E;
    localparam logic [7:0] ADDR_CAL_STAT   = 8'h0F;
    localparam logic [7:0] ADDR_MEM_CTL    = 8'h12;
    localparam logic [7:0] ADDR_IRQ_STAT   = 8'h20;
    localparam logic [7:0] ADDR_IRQ_MASK   = 8'h21;
    // Aux control field positions
    localparam int AUX_EN_BIT   = 7;
    localparam int AUX_SPAN_LSB = 5;
    localparam int AUX_TOP_LSB  = 2;
    localparam int AUX_MSB_LSB  = 0;
    // Calibration control field positions
    localparam int CAL_PRE_Q_BIT  = 7;
    localparam int CAL_PRE_I_BIT  = 6;
    localparam int CAL_PICK_Q_BIT = 5;
    localparam int CAL_PICK_I_BIT = 4;
    localparam int CAL_GATE_BIT   = 3;
    localparam int CAL_DIV_LSB    = 0;
    localparam int Q_DONE_BIT     = 7;
    localparam int START_BIT      = 4;
    // Interrupt status bits
    localparam int IRQ_DONE_BIT  = 0;
    localparam int IRQ_START_BIT = 1;
    // Reset values
    localparam logic [7:0] RST_AUX_LOW  = 8'h00;
    localparam logic [7:0] RST_AUX_CTL  = 8'h00;
    localparam logic [5:0] RST_REF_TRIM = 6'h00;
    localparam logic [7:0] RST_CAL_CTL  = 8'h00;
    localparam logic [1:0] RST_IRQ      = 2'h0;
    // Fixed calibration reference preload
    localparam logic [5:0] PRELOAD_FIXED = 6'h20;
    // Calibration clock ticks one calibration run lasts
    localparam logic [7:0] CAL_RUN_TICKS = 8'h10;
    // Calibration sequencer states
    typedef enum logic [0:0] {
        CAL_IDLE = 1'b0,
        CAL_RUN  = 1'b1
    } cal_state_t;
endpackage

//--- core/aux_ref_cal_control_regs.sv
// Aux converter, reference trim and calibration control register slice
//
// What this block does
// - Q aux word: low byte plus control bits 1:0
// - Q word 3FF full, 200 mid, resets 000
// - Q control bit 7 enables output, reset off
// - Q span field bits 6:5, reset 2 V
// - Q top field bits 4:2, reset 1.0 V
// - I control bits 1:0 are I word MSBs
// - I top field decodes like Q top field
// - Six-bit signed reference trim, reset zero
// - Q preload: 32 when clear, user when set
// - I preload: 32 when clear, user when set
// - Bit 5 picks Q for self-calibration
// - Bit 4 picks I for self-calibration
// - Bit 3 gates calibration clock, reset off
// - Divider field 000 is 256 down to 2
// - Status bit 7: Q calibration done flag
// - Writing one to start bit starts calibration
`timescale 1ns/1ps
module aux_ref_cal_control_regs
    import aux_cal_pkg::*;
(
    // Clock and reset
    input  wire logic       i_clk,
    input  wire logic       i_srst,
    // Register port
    input  wire logic [7:0] i_addr,
    input  wire logic [7:0] i_wdata,
    input  wire logic       i_wr,
    input  wire logic       i_rd,
    output logic      [7:0] o_rdata,
    // User calibration reference from calibration address 1
    input  wire logic [5:0] i_cal_user_ref,
    // I aux converter settings
    output logic      [9:0] o_aux_i_word,
    output logic            o_aux_i_output_on,
    output logic      [1:0] o_aux_i_span_sel,
    output logic      [2:0] o_aux_i_top_sel,
    // Q aux converter settings
    output logic      [9:0] o_aux_q_word,
    output logic            o_aux_q_output_on,
    output logic      [1:0] o_aux_q_span_sel,
    output logic      [2:0] o_aux_q_top_sel,
    // Reference trim
    output logic      [5:0] o_reference_trim_code,
    // Calibration controls
    output logic      [5:0] o_q_cal_preload,
    output logic      [5:0] o_i_cal_preload,
    output logic            o_q_selfcal_pick,
    output logic            o_i_selfcal_pick,
    output logic            o_cal_clk,
    output logic            o_cal_busy,
    output logic            o_q_cal_done_flag,
    // Interrupt
    output logic            o_irq
);

    // Whole register state of the block
    //
    // Everything that remembers a value lives in this one struct, so the
    // reset branch and the next-state process can never drift apart.
    // The fields fall into four groups:
    //   - software registers, stored as written, trim and mask cut to their width
    //   - calibration clock divider and its divided output
    //   - calibration run sequencer with its tick counter
    //   - interrupt status, mask and the registered read data
    // Preload values are kept here as well so that the preload outputs
    // come from flip-flops and never glitch when the user value moves.
    typedef struct packed {
        logic [7:0] aux_i_low;    // I word low byte
        logic [7:0] aux_i_ctl;    // I control
        logic [7:0] aux_q_low;    // Q word low byte
        logic [7:0] aux_q_ctl;    // Q control
        logic [5:0] ref_trim;     // Reference trim code
        logic [7:0] cal_ctl;      // Calibration control
        logic       q_done;       // Q calibration complete
        cal_state_t cal_state;    // Calibration sequencer
        logic [7:0] div_cnt;      // Calibration clock divider count
        logic       cal_clk;      // Divided calibration clock
        logic [7:0] tick_cnt;     // Calibration ticks in this run
        logic       run_q;        // Q taken into current run
        logic [1:0] irq_stat;     // Sticky event bits
        logic [1:0] irq_mask;     // Event enables
        logic [7:0] rdata;        // Read data, one cycle late
        logic [5:0] q_pre;        // Q preload value
        logic [5:0] i_pre;        // I preload value
    } state_t;

    state_t st_reg;   // Registered state
    state_t st_next;  // Next state

    // Function helpers
    //
    // The decodes below are written as functions; preload and hit are used
    // in more than one place. They are pure: no state is touched,
    // which keeps the next-state process readable and easy to check.

    // Divide ratio minus one for a divider code, halving per step
    // Code 0 gives 256, code 7 gives 2; the middle codes are assumed
    // to keep halving. The result fits eight bits because the largest
    // terminal count is 255.
    function automatic logic [7:0] div_last(input logic [2:0] code);
        logic [8:0] ratio;
        ratio = 9'h100 >> code;
        return 8'(ratio - 9'h001);
    endfunction

    // Preload choice: fixed 32 or the user value
    // The user value is sampled every cycle; software should settle it
    // before setting the select bit, since no snapshot is taken.
    function automatic logic [5:0] preload(input logic sel, input logic [5:0] user);
        return sel ? user : PRELOAD_FIXED;
    endfunction

    // Register read mux; unmapped and reserved bits give zero
    // The memory control address is write-only and falls to the
    // default branch. Status reads have no side effect, so a read
    // can never lose a sticky event.
    function automatic logic [7:0] read_mux(input state_t s, input logic [7:0] a);
        logic [7:0] d;
        d = 8'h00;
        case (a)
            ADDR_AUX_I_LOW: d = s.aux_i_low;
            ADDR_AUX_I_CTL: d = s.aux_i_ctl;
            ADDR_AUX_Q_LOW: d = s.aux_q_low;
            ADDR_AUX_Q_CTL: d = s.aux_q_ctl;
            ADDR_REF_TRIM:  d = {2'h0, s.ref_trim};
            ADDR_CAL_CTL:   d = s.cal_ctl;
            ADDR_CAL_STAT:  d[Q_DONE_BIT] = s.q_done;
            ADDR_IRQ_STAT:  d = {6'h00, s.irq_stat};
            ADDR_IRQ_MASK:  d = {6'h00, s.irq_mask};
            default:        d = 8'h00;
        endcase
        return d;
    endfunction

    // Write decode helper
    // Full eight-bit compare, so aliases never hit a register.
    function automatic logic hit(input logic wr, input logic [7:0] a, input logic [7:0] t);
        return wr && (a == t);
    endfunction

    // Next-state logic for registers, divider and calibration run
    //
    // Order inside this process matters only for the interrupt status:
    // the write-one clear is applied first and the event sets after it,
    // so an event in the same cycle as a clear is never lost.
    // Writes to separate registers never overlap, so their order is free.
    always_comb begin
        logic       start;
        logic       tick;
        logic       done_evt;
        logic [7:0] last;
        start    = 1'b0;
        tick     = 1'b0;
        done_evt = 1'b0;
        last     = 8'h00;
        st_next  = st_reg;

        // Plain read/write registers
        if (hit(i_wr, i_addr, ADDR_AUX_I_LOW)) begin
            st_next.aux_i_low = i_wdata;
        end
        if (hit(i_wr, i_addr, ADDR_AUX_I_CTL)) begin
            st_next.aux_i_ctl = i_wdata;
        end
        if (hit(i_wr, i_addr, ADDR_AUX_Q_LOW)) begin
            st_next.aux_q_low = i_wdata;
        end
        if (hit(i_wr, i_addr, ADDR_AUX_Q_CTL)) begin
            st_next.aux_q_ctl = i_wdata;
        end
        if (hit(i_wr, i_addr, ADDR_REF_TRIM)) begin
            st_next.ref_trim = i_wdata[5:0];
        end
        if (hit(i_wr, i_addr, ADDR_CAL_CTL)) begin
            st_next.cal_ctl = i_wdata;
        end
        if (hit(i_wr, i_addr, ADDR_IRQ_MASK)) begin
            st_next.irq_mask = i_wdata[1:0];
        end

        // Start strobe; a zero write does nothing
        start = hit(i_wr, i_addr, ADDR_MEM_CTL) && i_wdata[START_BIT];

        // Divider runs only while the gate bit is set, so it stops clean
        // The divided clock is high for the upper half of each count.
        // Every ratio is even, so the high and low phases are equal; the
        // consumer only uses rising edges, so duty cycle is not critical.
        // Each wrap also gives one tick to the calibration sequencer.
        last = div_last(st_reg.cal_ctl[CAL_DIV_LSB +: 3]);
        if (!st_reg.cal_ctl[CAL_GATE_BIT]) begin
            st_next.div_cnt = 8'h00;
            st_next.cal_clk = 1'b0;
        end else if (st_reg.div_cnt >= last) begin
            // Wrap also covers a divider code shrunk mid-count
            st_next.div_cnt = 8'h00;
            st_next.cal_clk = 1'b0;
            tick            = 1'b1;
        end else begin
            st_next.div_cnt = st_reg.div_cnt + 8'h01;
            st_next.cal_clk = (st_reg.div_cnt + 8'h01) > (last >> 1);
        end

        // Calibration sequencer, counting divided clock ticks
        // A start while a run is active is ignored by the sequencer;
        // only the start event bit records it. The Q pick bit is
        // latched at start so a later change does not alter the run.
        // Only the Q completion flag is kept in this slice.
        case (st_reg.cal_state)
            CAL_IDLE: begin
                if (start) begin
                    st_next.cal_state = CAL_RUN;
                    st_next.tick_cnt  = 8'h00;
                    st_next.run_q     = st_reg.cal_ctl[CAL_PICK_Q_BIT];
                    if (st_reg.cal_ctl[CAL_PICK_Q_BIT]) begin
                        st_next.q_done = 1'b0;
                    end
                end
            end
            CAL_RUN: begin
                // A run cannot progress while the clock is gated off
                if (tick) begin
                    if (st_reg.tick_cnt == CAL_RUN_TICKS - 8'h01) begin
                        st_next.cal_state = CAL_IDLE;
                        done_evt          = 1'b1;
                        if (st_reg.run_q) begin
                            st_next.q_done = 1'b1;
                        end
                    end else begin
                        st_next.tick_cnt = st_reg.tick_cnt + 8'h01;
                    end
                end
            end
            default: begin
                st_next.cal_state = CAL_IDLE;
            end
        endcase

        // Sticky events: write-one clears, a same-cycle set wins
        // Bit 0 marks the end of a run, bit 1 a start request.
        // The interrupt output is the OR of the masked bits.
        if (hit(i_wr, i_addr, ADDR_IRQ_STAT)) begin
            st_next.irq_stat = st_reg.irq_stat & ~i_wdata[1:0];
        end
        if (done_evt) begin
            st_next.irq_stat[IRQ_DONE_BIT] = 1'b1;
        end
        if (start) begin
            st_next.irq_stat[IRQ_START_BIT] = 1'b1;
        end

        // Preload selection, registered for clean outputs
        st_next.q_pre = preload(st_reg.cal_ctl[CAL_PRE_Q_BIT], i_cal_user_ref);
        st_next.i_pre = preload(st_reg.cal_ctl[CAL_PRE_I_BIT], i_cal_user_ref);

        // Read data valid only in the cycle after the strobe
        // Zero outside that cycle keeps a shared read bus quiet.
        st_next.rdata = i_rd ? read_mux(st_reg, i_addr) : 8'h00;
    end

    // State register with synchronous reset to defaults
    //
    // The whole struct is cleared first, then the fields whose default
    // is not zero, or whose default is worth naming, are set by name.
    // Reset is synchronous, so it must be held for at least one edge.
    // The divider, tick counter and run flag all restart at zero,
    // and the gate bit resets clear, which leaves the calibration clock stopped after reset.
    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            st_reg           <= '0;
            st_reg.aux_i_low <= RST_AUX_LOW;
            st_reg.aux_i_ctl <= RST_AUX_CTL;
            st_reg.aux_q_low <= RST_AUX_LOW;
            st_reg.aux_q_ctl <= RST_AUX_CTL;
            st_reg.ref_trim  <= RST_REF_TRIM;
            st_reg.cal_ctl   <= RST_CAL_CTL;
            st_reg.cal_state <= CAL_IDLE;
            st_reg.irq_stat  <= RST_IRQ;
            st_reg.irq_mask  <= RST_IRQ;
            st_reg.q_pre     <= PRELOAD_FIXED;
            st_reg.i_pre     <= PRELOAD_FIXED;
        end else begin
            st_reg <= st_next;
        end
    end

    // Output drive, all from state flip-flops
    //
    // Pure wiring: no logic between the flip-flops and the pins except
    // the interrupt OR. Fields keep their bit layout from the control
    // registers, so software and hardware see the same code.
    // Top codes above 100 are passed through unchanged.
    always_comb begin
        o_rdata               = st_reg.rdata;
        o_aux_i_word          = {st_reg.aux_i_ctl[AUX_MSB_LSB +: 2], st_reg.aux_i_low};
        o_aux_i_output_on     = st_reg.aux_i_ctl[AUX_EN_BIT];
        o_aux_i_span_sel      = st_reg.aux_i_ctl[AUX_SPAN_LSB +: 2];
        o_aux_i_top_sel       = st_reg.aux_i_ctl[AUX_TOP_LSB +: 3];
        o_aux_q_word          = {st_reg.aux_q_ctl[AUX_MSB_LSB +: 2], st_reg.aux_q_low};
        o_aux_q_output_on     = st_reg.aux_q_ctl[AUX_EN_BIT];
        o_aux_q_span_sel      = st_reg.aux_q_ctl[AUX_SPAN_LSB +: 2];
        o_aux_q_top_sel       = st_reg.aux_q_ctl[AUX_TOP_LSB +: 3];
        o_reference_trim_code = st_reg.ref_trim;
        o_q_cal_preload       = st_reg.q_pre;
        o_i_cal_preload       = st_reg.i_pre;
        o_q_selfcal_pick      = st_reg.cal_ctl[CAL_PICK_Q_BIT];
        o_i_selfcal_pick      = st_reg.cal_ctl[CAL_PICK_I_BIT];
        o_cal_clk             = st_reg.cal_clk;
        o_cal_busy            = (st_reg.cal_state == CAL_RUN);
        o_q_cal_done_flag     = st_reg.q_done;
        o_irq                 = |(st_reg.irq_stat & st_reg.irq_mask);
    end

endmodule

//--- tb/aux_ref_cal_chk.sv
// Port-level assertions for the aux/ref/cal register slice
`timescale 1ns/1ps
module aux_ref_cal_chk
    import aux_cal_pkg::*;
(
    // Clock, reset and register port
    input wire logic       i_clk,
    input wire logic       i_srst,
    input wire logic [7:0] i_addr,
    input wire logic [7:0] i_wdata,
    input wire logic       i_wr,
    input wire logic       i_rd,
    input wire logic [7:0] o_rdata,
    // Field and status outputs
    input wire logic [9:0] o_aux_i_word,
    input wire logic [9:0] o_aux_q_word,
    input wire logic [5:0] o_aux_q_ctl_view,
    input wire logic [5:0] o_reference_trim_code,
    input wire logic [5:0] o_q_cal_preload,
    input wire logic       o_q_selfcal_pick,
    input wire logic       o_cal_clk,
    input wire logic       o_cal_busy,
    input wire logic       o_q_cal_done_flag,
    input wire logic       o_irq
);
    // Single domain, so clock and reset are set once
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (i_srst);
    property p_q_low; i_wr && i_addr == ADDR_AUX_Q_LOW |=> o_aux_q_word[7:0] == $past(i_wdata); endproperty
    a_q_low: assert property (p_q_low) else $error("q low byte not taken");
    property p_q_ctl; i_wr && i_addr == ADDR_AUX_Q_CTL |=> {o_aux_q_ctl_view, o_aux_q_word[9:8]} == $past(i_wdata); endproperty
    a_q_ctl: assert property (p_q_ctl) else $error("q control fields wrong");
    property p_i_msb; i_wr && i_addr == ADDR_AUX_I_CTL |=> o_aux_i_word[9:8] == $past(i_wdata[1:0]); endproperty
    a_i_msb: assert property (p_i_msb) else $error("i word msbs wrong");
    property p_ref; i_wr && i_addr == ADDR_REF_TRIM |=> o_reference_trim_code == $past(i_wdata[5:0]); endproperty
    a_ref: assert property (p_ref) else $error("trim code wrong");
    property p_rst; $past(i_srst) |-> o_aux_q_word == 10'h000 && o_q_cal_preload == PRELOAD_FIXED && !o_cal_clk && !o_irq && !o_q_cal_done_flag; endproperty
    a_rst: assert property (p_rst) else $error("reset values wrong");
    property p_rd_idle; !$past(i_rd) |-> o_rdata == 8'h00; endproperty
    a_rd_idle: assert property (p_rd_idle) else $error("read data outside slot");
    property p_unmapped; i_rd && i_addr == 8'h30 |=> o_rdata == 8'h00; endproperty
    a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
    property p_start; i_wr && i_addr == ADDR_MEM_CTL && i_wdata[START_BIT] && !o_cal_busy |=> o_cal_busy; endproperty
    a_start: assert property (p_start) else $error("start ignored");
    property p_start0; i_wr && i_addr == ADDR_MEM_CTL && !i_wdata[START_BIT] && !o_cal_busy |=> !o_cal_busy; endproperty
    a_start0: assert property (p_start0) else $error("zero write started a run");
    property p_qclr; $rose(o_cal_busy) && o_q_selfcal_pick |-> !o_q_cal_done_flag; endproperty
    a_qclr: assert property (p_qclr) else $error("done not cleared at start");
    property p_qdone; $fell(o_cal_busy) && o_q_selfcal_pick |-> ##[0:1] o_q_cal_done_flag; endproperty
    a_qdone: assert property (p_qdone) else $error("done not set at end");
endmodule
bind aux_ref_cal_control_regs aux_ref_cal_chk u_chk (.i_clk(i_clk), .i_srst(i_srst),
    .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
    .o_aux_i_word(o_aux_i_word), .o_aux_q_word(o_aux_q_word),
    .o_aux_q_ctl_view({o_aux_q_output_on, o_aux_q_span_sel, o_aux_q_top_sel}),
    .o_reference_trim_code(o_reference_trim_code), .o_q_cal_preload(o_q_cal_preload),
    .o_q_selfcal_pick(o_q_selfcal_pick), .o_cal_clk(o_cal_clk), .o_cal_busy(o_cal_busy),
    .o_q_cal_done_flag(o_q_cal_done_flag), .o_irq(o_irq));

//--- tb/tb_top.sv
// Self-checking bench of the aux/ref/cal register slice
`timescale 1ns/1ps
module tb_top;
    import aux_cal_pkg::*;
    logic       i_clk, i_srst, i_wr, i_rd, qon, ion, qpk, ipk, cclk, busy, qdone, irq;
    logic [7:0] i_addr, i_wdata, o_rdata;
    logic [5:0] i_cal_user_ref, trim, qpre, ipre;
    logic [9:0] iword, qword;
    logic [1:0] ispan, qspan;
    logic [2:0] itop, qtop;
    int         bad_count, samples_checked, cycles;
    aux_ref_cal_control_regs dut (.i_clk(i_clk), .i_srst(i_srst), .i_addr(i_addr),
        .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
        .i_cal_user_ref(i_cal_user_ref), .o_aux_i_word(iword), .o_aux_i_output_on(ion),
        .o_aux_i_span_sel(ispan), .o_aux_i_top_sel(itop), .o_aux_q_word(qword),
        .o_aux_q_output_on(qon), .o_aux_q_span_sel(qspan), .o_aux_q_top_sel(qtop),
        .o_reference_trim_code(trim), .o_q_cal_preload(qpre), .o_i_cal_preload(ipre),
        .o_q_selfcal_pick(qpk), .o_i_selfcal_pick(ipk), .o_cal_clk(cclk),
        .o_cal_busy(busy), .o_q_cal_done_flag(qdone), .o_irq(irq));
    // 25 MHz sample clock
    initial begin
        i_clk = 1'b0;
        forever #20 i_clk = ~i_clk;
    end
    // Hang guard, well above the divider sweep length
    always @(posedge i_clk) begin
        cycles++;
        if (cycles == 30000) begin
            bad_count++;
            results();
        end
    end
    task automatic results;
        $display("checks=%0d mismatches=%0d", samples_checked, bad_count);
        if (bad_count == 0 && samples_checked > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    task automatic check(input logic [23:0] seen, input logic [23:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            bad_count++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    // Step just past an edge so updates have landed
    task automatic tick(input int n = 1);
        repeat (n) @(posedge i_clk);
        #1;
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        i_wr <= 1'b1;
        i_addr <= a;
        i_wdata <= d;
        tick();
        i_wr <= 1'b0;
        tick();
    endtask
    // Read data only stands in the slot after the strobe
    task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
        i_rd <= 1'b1;
        i_addr <= a;
        tick();
        i_rd <= 1'b0;
        check(o_rdata, exp);
        tick();
    endtask
    // Cycles from one divided-clock rise to the next
    task automatic wait_rise(output int n);
        n = 0;
        while (cclk === 1'b1 && n < 600) begin
            tick();
            n++;
        end
        while (cclk !== 1'b1 && n < 600) begin
            tick();
            n++;
        end
    endtask
    task automatic t_reset;
        check({qpre, ipre}, {PRELOAD_FIXED, PRELOAD_FIXED});
        check({qword, iword}, 20'h0);
        check({qon, qspan, qtop, trim}, 12'h0);
        check({qpk, ipk, cclk, busy, qdone, irq}, 6'h00);
        for (int a = 9; a < 16; a++) rd_chk(8'(a), 8'h00);
    endtask
    task automatic t_aux;
        wr(ADDR_AUX_Q_LOW, 8'hFF);
        wr(ADDR_AUX_Q_CTL, 8'h03);
        check(qword, 10'h3FF);
        wr(ADDR_AUX_Q_LOW, 8'h00);
        wr(ADDR_AUX_Q_CTL, 8'h02);
        check(qword, 10'h200);
        rd_chk(ADDR_AUX_Q_CTL, 8'h02);
        wr(ADDR_AUX_I_LOW, 8'hA5);
        // Every span code against every documented top code
        for (logic [5:0] v = 0; v < 20; v++) begin
            wr(ADDR_AUX_Q_CTL, {1'b1, v[1:0], v[4:2], 2'b01});
            check({qon, qspan, qtop, qword}, {1'b1, v[1:0], v[4:2], 10'h100});
            wr(ADDR_AUX_I_CTL, {1'b0, v[1:0], v[4:2], v[1:0]});
            check({ion, ispan, itop, iword}, {1'b0, v[1:0], v[4:2], v[1:0], 8'hA5});
        end
        wr(ADDR_AUX_Q_CTL, 8'h00);
        check(qon, 1'b0);
        wr(ADDR_REF_TRIM, 8'hFF);
        check(trim, 6'h3F);
        rd_chk(ADDR_REF_TRIM, 8'h3F);
    endtask
    task automatic t_preload;
        i_cal_user_ref <= 6'h15;
        wr(ADDR_CAL_CTL, 8'hC0);
        check({qpre, ipre}, {6'h15, 6'h15});
        wr(ADDR_CAL_CTL, 8'h40);
        check({qpre, ipre}, {PRELOAD_FIXED, 6'h15});
        wr(ADDR_CAL_CTL, 8'h20);
        check({qpk, ipk}, 2'b10);
        wr(ADDR_CAL_CTL, 8'h10);
        check({qpk, ipk}, 2'b01);
        rd_chk(ADDR_CAL_CTL, 8'h10);
    endtask
    task automatic t_div;
        int n;
        for (int c = 0; c < 8; c++) begin
            wr(ADDR_CAL_CTL, 8'h08 | 8'(c));
            wait_rise(n);
            wait_rise(n);
            check(24'(n), 24'(256 >> c));
        end
        // Gate off must hold the divided clock low
        wr(ADDR_CAL_CTL, 8'h07);
        n = 0;
        repeat (40) begin
            tick();
            if (cclk !== 1'b0) n++;
        end
        check(24'(n), 24'h0);
    endtask
    task automatic run_cal(output int n);
        wr(ADDR_MEM_CTL, 8'h10);
        n = 0;
        while (busy === 1'b1 && n < 200) begin
            tick();
            n++;
        end
        tick();
    endtask
    task automatic t_cal;
        int n;
        wr(ADDR_IRQ_MASK, 8'h03);
        wr(ADDR_CAL_CTL, 8'h2F);
        wr(ADDR_MEM_CTL, 8'h00);
        check(busy, 1'b0);
        run_cal(n);
        check(24'(n >= 28 && n <= 36), 24'h1);
        check({qdone, irq}, 2'b11);
        rd_chk(ADDR_CAL_STAT, 8'h80);
        rd_chk(ADDR_IRQ_STAT, 8'h03);
        wr(ADDR_IRQ_STAT, 8'h03);
        check(irq, 1'b0);
        // Masked run without Q picked keeps the flag and stays quiet
        wr(ADDR_IRQ_MASK, 8'h00);
        wr(ADDR_CAL_CTL, 8'h0F);
        run_cal(n);
        check({qdone, irq}, 2'b10);
        wr(ADDR_IRQ_MASK, 8'h01);
        check(irq, 1'b1);
    endtask
    initial begin
        i_srst = 1'b1;
        i_wr = 1'b0;
        i_rd = 1'b0;
        i_addr = 8'h00;
        i_wdata = 8'h00;
        i_cal_user_ref = 6'h00;
        tick(16);
        i_srst <= 1'b0;
        tick();
        t_reset();
        t_aux();
        t_preload();
        t_div();
        t_cal();
        rd_chk(8'h30, 8'h00);
        results();
    end
endmodule
